// ===== eeprom_host_pkg.sv
// Package of constants for the parallel EEPROM host controller.
package eeprom_host_pkg;

  // ---------------------------------------------------------------------------
  // Geometry
  // ---------------------------------------------------------------------------
  localparam int ADDR_W      = 16;
  localparam int DATA_W      = 8;
  localparam int PAGE_LSB    = 7;
  localparam int PAGE_BYTES  = 128;
  localparam int POLL_BIT    = 7;
  localparam int TOGGLE_BIT  = 6;
  localparam int CMD_IGN_BIT = 15;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_PS    = 5000;
  localparam int BYTE_LOAD_US     = 100;
  localparam int BYTE_LOAD_CYC    = (BYTE_LOAD_US * 1000000) / CLK_PERIOD_PS;
  localparam int WRITE_CYCLE_MS   = 5;
  localparam int WRITE_CYCLE_CYC  = (WRITE_CYCLE_MS * 1000000) / (CLK_PERIOD_PS / 1000);
  localparam int STROBE_NS        = 30;
  localparam int STROBE_CYC       = (STROBE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int PAGE_GAP_NS      = 50000;
  localparam int PAGE_GAP_CYC     = (PAGE_GAP_NS * 1000) / CLK_PERIOD_PS;

  // ---------------------------------------------------------------------------
  // Protection command sequences (values arbitrary, set per part)
  // ---------------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] PROT_A1 = 16'h1111;
  localparam logic [ADDR_W-1:0] PROT_A2 = 16'h2222;
  localparam logic [DATA_W-1:0] PROT_D1 = 8'h11;
  localparam logic [DATA_W-1:0] PROT_D2 = 8'h22;
  localparam logic [DATA_W-1:0] PROT_D3 = 8'h33;
  localparam logic [DATA_W-1:0] UNPROT_D3 = 8'h44;
  localparam logic [DATA_W-1:0] UNPROT_D6 = 8'h55;

  // Command codes on the user port.
  localparam logic [1:0] CMD_READ    = 2'h0;
  localparam logic [1:0] CMD_WRITE   = 2'h1;
  localparam logic [1:0] CMD_PROTECT = 2'h2;
  localparam logic [1:0] CMD_UNPROT  = 2'h3;

endpackage : eeprom_host_pkg

// ===== eeprom_host.sv
// Host controller and command FIFO for a byte-wide parallel EEPROM.
`timescale 1ns/10ps
// Functional notes
// - Read is active while chip select and output strobe are both low.
// - Write needs chip select and write strobe low with output strobe high.
// - Page address bits 7 to 15 stay the same for every byte of a page.
// - Each next byte falling edge comes within 100 us of the previous one.
// - With protection on, every write is preceded by the three-write sequence; the host sends it only for a queued CMD_PROTECT entry.
// - A six-write sequence clears protection after one write cycle time.
// - Command sequences are issued without other accesses in between.
// - Chip select must be low for any access to take effect.

module byte_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_r;
  logic [AW-1:0]    rd_r;
  logic [AW:0]      cnt_r;
  logic             push;
  logic             pop;

  // Honest full and empty from the occupancy count.
  assign in_ready  = (cnt_r != AW'(0) + (AW+1)'(DEPTH));
  assign out_valid = (cnt_r != '0);
  assign out_data  = mem[rd_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage write.
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wr_r  <= '0;
      rd_r  <= '0;
      cnt_r <= '0;
    end else begin
      if (push) begin
        wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
      end
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : byte_fifo

module eeprom_host #(
  parameter int BYTE_LOAD_CYC   = eeprom_host_pkg::BYTE_LOAD_CYC,
  parameter int WRITE_CYCLE_CYC = eeprom_host_pkg::WRITE_CYCLE_CYC,
  parameter int PAGE_GAP_CYC    = eeprom_host_pkg::PAGE_GAP_CYC,
  parameter int FIFO_DEPTH      = 8
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // User command port.
  input  wire logic [1:0]  cmd,
  input  wire logic [15:0] cmd_addr,
  input  wire logic [7:0]  cmd_data,
  input  wire logic        cmd_last,
  input  wire logic        cmd_valid,
  output logic             cmd_ready,
  output logic [7:0]       rd_data,
  output logic             rd_valid,
  output logic             busy,
  // Device pins.
  output logic [15:0]      byte_address,
  output logic             chip_sel_n,
  output logic             out_en_n,
  output logic             wr_en_n,
  input  wire logic [7:0]  data_lines_in,
  output logic [7:0]       data_lines_out,
  output logic             data_lines_oe_n
);
  localparam int SC = eeprom_host_pkg::STROBE_CYC;
  localparam int TW = $clog2(WRITE_CYCLE_CYC + 2);
  // The wait for a further byte never outlasts the byte load timeout, so an open page
  // is closed by this controller and not by the device.
  localparam int GAP_CYC = (PAGE_GAP_CYC < BYTE_LOAD_CYC) ? PAGE_GAP_CYC
                                                          : BYTE_LOAD_CYC - 1;

  typedef enum {
    ST_IDLE, ST_RD_SET, ST_RD_HOLD, ST_WR_SET, ST_WR_LOW, ST_WR_HIGH,
    ST_GAP, ST_POLL_A, ST_POLL_B, ST_DONE
  } state_t;

  state_t          state_r;
  logic [TW-1:0]   tmr_r;
  logic [23:0]     q_data;
  logic            q_valid;
  logic            q_ready;
  logic [1:0]      q_cmd;
  logic            q_last;
  logic [2:0]      seq_r;
  logic [2:0]      seq_len_r;
  logic [15:0]     page_r;
  logic [7:0]      last_d_r;
  logic [7:0]      poll_r;
  logic            is_rd_r;
  logic            have_prev_r;
  logic            q_take;

  // Command word: cmd, last, address, data; the FIFO stalls the user port.
  byte_fifo #(.WIDTH(27), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .in_data   ({cmd, cmd_last, cmd_addr, cmd_data}),
    .in_valid  (cmd_valid),
    .in_ready  (cmd_ready),
    .out_data  ({q_cmd, q_last, q_data}),
    .out_valid (q_valid),
    .out_ready (q_ready)
  );

  // Sequence word for command step n; A15 is left low as it is ignored.
  function automatic logic [23:0] seq_word(input logic [2:0] n, input logic unp);
    logic [7:0] d3;
    d3 = unp ? eeprom_host_pkg::UNPROT_D3 : eeprom_host_pkg::PROT_D3;
    case (n)
      3'd0, 3'd3: seq_word = {eeprom_host_pkg::PROT_A1, eeprom_host_pkg::PROT_D1};
      3'd1, 3'd4: seq_word = {eeprom_host_pkg::PROT_A2, eeprom_host_pkg::PROT_D2};
      3'd2:       seq_word = {eeprom_host_pkg::PROT_A1, d3};
      default:    seq_word = {eeprom_host_pkg::PROT_A1, eeprom_host_pkg::UNPROT_D6};
    endcase
  endfunction : seq_word

  // Only words that the sequencer acts on in this cycle leave the FIFO; a write for
  // another page, or one after the closing byte, waits until polling has ended.
  assign q_take    = q_valid && seq_r == 3'd0 &&
                     (state_r == ST_IDLE ||
                      (state_r == ST_GAP && !is_rd_r && q_cmd == eeprom_host_pkg::CMD_WRITE &&
                       q_data[23:15] == page_r[15:7]));
  assign q_ready   = q_take;
  assign busy      = (state_r != ST_IDLE);

  // Strobes are decoded from state; only one access kind is ever active.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      chip_sel_n      <= 1'b1;
      out_en_n        <= 1'b1;
      wr_en_n         <= 1'b1;
      data_lines_oe_n <= 1'b1;
    end else begin
      chip_sel_n      <= !(state_r == ST_RD_SET || state_r == ST_RD_HOLD ||
                           state_r == ST_WR_SET || state_r == ST_WR_LOW ||
                           state_r == ST_POLL_A);
      out_en_n        <= !(state_r == ST_RD_SET || state_r == ST_RD_HOLD ||
                           state_r == ST_POLL_A);
      // Write strobe held low for STROBE_CYC + 1 cycles, far above the noise filter.
      wr_en_n         <= !(state_r == ST_WR_LOW);
      data_lines_oe_n <= !(state_r == ST_WR_SET || state_r == ST_WR_LOW ||
                           state_r == ST_WR_HIGH);
    end
  end

  // Access sequencer: reads, page loads, command sequences and polling.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_r        <= ST_IDLE;
      tmr_r          <= '0;
      seq_r          <= '0;
      seq_len_r      <= '0;
      page_r         <= '0;
      last_d_r       <= '0;
      poll_r         <= '0;
      is_rd_r        <= 1'b0;
      have_prev_r    <= 1'b0;
      byte_address   <= '0;
      data_lines_out <= '0;
      rd_data        <= '0;
      rd_valid       <= 1'b0;
    end else begin
      rd_valid <= 1'b0;
      tmr_r    <= (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
      case (state_r)
        ST_IDLE, ST_GAP: begin
          if (seq_r != 3'd0) begin
            // Command steps go out back to back, nothing in between.
            {byte_address, data_lines_out} <= seq_word(seq_r - 3'd1, seq_len_r == 3'd6);
            state_r <= ST_WR_SET;
            tmr_r   <= TW'(SC);
          end else if (q_take && (q_cmd == eeprom_host_pkg::CMD_PROTECT ||
                                  q_cmd == eeprom_host_pkg::CMD_UNPROT)) begin
            // Command words carry no data; the entry leaves the FIFO here.
            seq_len_r <= (q_cmd == eeprom_host_pkg::CMD_UNPROT) ? 3'd6 : 3'd3;
            seq_r     <= 3'd1;
          end else if (q_take && q_cmd == eeprom_host_pkg::CMD_READ) begin
            byte_address <= q_data[23:8];
            state_r      <= ST_RD_SET;
            tmr_r        <= TW'(SC);
          end else if (q_take && q_cmd == eeprom_host_pkg::CMD_WRITE) begin
            byte_address   <= q_data[23:8];
            data_lines_out <= q_data[7:0];
            page_r         <= q_data[23:8];
            last_d_r       <= q_data[7:0];
            is_rd_r        <= q_last;
            state_r        <= ST_WR_SET;
            tmr_r          <= TW'(SC);
          end else if (state_r == ST_GAP && (tmr_r == '0 || is_rd_r)) begin
            // Stopping loads; the first status read ends the load and starts programming.
            byte_address <= page_r;
            state_r      <= ST_POLL_A;
            tmr_r        <= TW'(WRITE_CYCLE_CYC);
            have_prev_r  <= 1'b0;
          end
        end
        ST_RD_SET:  if (tmr_r == '0) begin
          rd_data  <= data_lines_in;
          rd_valid <= 1'b1;
          state_r  <= ST_RD_HOLD;
        end
        ST_RD_HOLD: state_r <= ST_DONE;
        ST_WR_SET:  begin
          state_r <= ST_WR_LOW;
          tmr_r   <= TW'(SC);
        end
        ST_WR_LOW:  if (tmr_r == '0) begin
          state_r <= ST_WR_HIGH;
        end
        ST_WR_HIGH: begin
          state_r <= ST_GAP;
          tmr_r   <= TW'(GAP_CYC);
          if (seq_r != 3'd0) begin
            // No page byte may join a command sequence, so the gap after it only polls.
            seq_r   <= (seq_r == seq_len_r) ? 3'd0 : seq_r + 3'd1;
            is_rd_r <= 1'b1;
            if (seq_r == seq_len_r && seq_len_r == 3'd3) begin
              // The protected page follows at once, with no status read in between.
              state_r <= ST_IDLE;
            end
          end
        end
        ST_POLL_A:  if (!out_en_n && tmr_r[1:0] == 2'b00) begin
          // Sample only once the read strobe has stood for a full cycle. Done when bit 7
          // equals that of the last byte written and bit 6 matches the previous, separate read; the timer bounds it.
          if ((data_lines_in[eeprom_host_pkg::POLL_BIT] == last_d_r[eeprom_host_pkg::POLL_BIT] &&
               have_prev_r &&
               data_lines_in[eeprom_host_pkg::TOGGLE_BIT] == poll_r[eeprom_host_pkg::TOGGLE_BIT])
              || tmr_r == '0) begin
            state_r <= ST_DONE;
          end else begin
            state_r <= ST_POLL_B;
          end
          poll_r      <= data_lines_in;
          have_prev_r <= 1'b1;
        end
        // One cycle with the strobes high ends the read, so the next one is a new read.
        ST_POLL_B:  state_r <= ST_POLL_A;
        default: state_r <= ST_IDLE;
      endcase
    end
  end
endmodule : eeprom_host

// ===== eeprom_host_asserts.sv
// Checker of the host controller's device-pin sequencing.
`timescale 1ns/10ps
module eeprom_host_asserts (
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic [15:0] byte_address,
  input wire logic        chip_sel_n,
  input wire logic        out_en_n,
  input wire logic        wr_en_n,
  input wire logic [7:0]  data_lines_out,
  input wire logic        data_lines_oe_n,
  input wire logic        rd_valid
);
  // ---------------------------------------------------------------------------
  // Pin sequencing properties
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  // Strobes are mutually exclusive and always qualified by the chip select.
  property p_wr_oe_high; !wr_en_n |-> out_en_n; endproperty
  a_wr_oe_high: assert property (p_wr_oe_high) else $error("write with output strobe low");
  property p_wr_sel; !wr_en_n |-> !chip_sel_n; endproperty
  a_wr_sel: assert property (p_wr_sel) else $error("write strobe without select");
  property p_rd_sel; !out_en_n |-> !chip_sel_n; endproperty
  a_rd_sel: assert property (p_rd_sel) else $error("output strobe without select");
  // The host must float its drivers whenever the device may drive the lines.
  property p_no_fight; !out_en_n |-> data_lines_oe_n; endproperty
  a_no_fight: assert property (p_no_fight) else $error("host drives during read");
  property p_wr_drive; !wr_en_n |-> !data_lines_oe_n; endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write strobe with lines floating");
  // Address and data must hold for the whole strobe, since the device latches at its edges.
  property p_wr_hold; !wr_en_n && $past(!wr_en_n) |-> $stable(byte_address) && $stable(data_lines_out); endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("address or data moved in strobe");
  property p_width; $fell(wr_en_n) |-> !wr_en_n [*6]; endproperty
  a_width: assert property (p_width) else $error("write strobe too short");
  property p_rd_hold; !out_en_n && $past(!out_en_n) |-> $stable(byte_address); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("address moved in read");
  c_write: cover property ($fell(wr_en_n));
  c_read: cover property ($fell(out_en_n));
  c_answer: cover property (rd_valid);
endmodule : eeprom_host_asserts

bind eeprom_host eeprom_host_asserts chk (.clk_sys(clk_sys), .rst(rst), .byte_address(byte_address),
  .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n), .rd_valid(rd_valid),
  .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n));

// ===== eeprom_model.sv
// Behavioural model of the byte-wide parallel EEPROM on the far side.
`timescale 1ns/10ps
module eeprom_model #(
  parameter int BL = 40,
  parameter int WC = 64
) (
  input wire logic        clk_sys,
  input wire logic [15:0] byte_address,
  input wire logic        chip_sel_n,
  input wire logic        out_en_n,
  input wire logic        wr_en_n,
  input wire logic [7:0]  bus,
  output logic [7:0]      dq
);
  // ---------------------------------------------------------------------------
  // Array, page buffer and protection state
  // ---------------------------------------------------------------------------
  logic [7:0]  mem [logic [15:0]];
  logic [15:0] pa [$];
  logic [7:0]  pd [$];
  logic [15:0] wa = 16'h0000;
  logic [7:0]  dl = 8'h00, ld = 8'h00, q = 8'h00;
  logic        prot = 1'b0, armed = 1'b0, tog = 1'b0, wr_q = 1'b0, rd_q = 1'b0, hit;
  int          tmo = 0, bsy = 0, wlen = 0;
  wire wr = !chip_sel_n && !wr_en_n && out_en_n;
  wire rd = !chip_sel_n && !out_en_n && wr_en_n;
  // Released lines show the inverse of the last read so a stale value never passes.
  assign dq = rd ? q : ~q;
  // Capture, page load, programming and status, sampled on the falling edge so that the
  // model never races the host, whose pins move and are sampled on the rising edge.
  always @(negedge clk_sys) begin
    if (wr && !wr_q) begin
      wa = byte_address;
      wlen = 0;
      tmo = 0;
    end
    if (wr) begin
      dl = bus;
      wlen++;
    end else if (tmo < BL) tmo++;
    hit = (wa & 16'h7FFF) == (eeprom_host_pkg::PROT_A1 & 16'h7FFF) ||
          (wa & 16'h7FFF) == (eeprom_host_pkg::PROT_A2 & 16'h7FFF);
    if (!wr && wr_q && wlen >= 2) begin
      if (hit && dl inside {eeprom_host_pkg::PROT_D1, eeprom_host_pkg::PROT_D2,
          eeprom_host_pkg::PROT_D3, eeprom_host_pkg::UNPROT_D3, eeprom_host_pkg::UNPROT_D6}) begin
        if (dl == eeprom_host_pkg::PROT_D3) {prot, armed} = 2'h3;
        if (dl == eeprom_host_pkg::UNPROT_D6) {prot, bsy} = {1'b0, WC};
      end else if (!prot || armed) begin
        pa.push_back(wa);
        pd.push_back(dl);
      end
    end
    // A read or the byte-load timeout ends the load and starts one shared programming cycle.
    if (pa.size() > 0 && (tmo >= BL || rd)) begin
      ld = pd[$];
      foreach (pa[i]) mem[pa[i]] = pd[i];
      pa.delete();
      pd.delete();
      bsy = WC;
      armed = 1'b0;
    end else if (bsy > 0) bsy--;
    if (rd && !rd_q) begin
      q = (bsy > 0) ? {~ld[7], tog, ld[5:0]} : mem[byte_address];
      if (bsy > 0) tog = ~tog;
    end
    wr_q = wr;
    rd_q = rd;
  end
endmodule : eeprom_model

// ===== tb_eeprom_host.sv
// Self-checking bench for the EEPROM host controller against a device model.
`timescale 1ns/10ps
module tb_eeprom_host;
  typedef struct packed {
    logic [1:0]  c;
    logic [15:0] a;
    logic [7:0]  d;
    logic        l;
    logic [7:0]  e;
  } row_t;
  localparam logic [1:0] RD = eeprom_host_pkg::CMD_READ;
  localparam logic [1:0] WR = eeprom_host_pkg::CMD_WRITE;
  // ---------------------------------------------------------------------------
  // Ordinary cases: page, polled byte, top half, protected write, unprotect
  // ---------------------------------------------------------------------------
  localparam row_t ROWS [14] = '{
    '{WR, 16'h0080, 8'hA5, 1'b0, 8'h00}, '{WR, 16'h0081, 8'h3C, 1'b1, 8'h00},
    '{RD, 16'h0080, 8'h00, 1'b0, 8'hA5}, '{RD, 16'h0081, 8'h00, 1'b0, 8'h3C},
    '{WR, 16'h0200, 8'h80, 1'b1, 8'h00}, '{RD, 16'h0200, 8'h00, 1'b0, 8'h80},
    '{WR, 16'h8300, 8'h7E, 1'b1, 8'h00}, '{RD, 16'h8300, 8'h00, 1'b0, 8'h7E},
    '{eeprom_host_pkg::CMD_PROTECT, 16'h0000, 8'h00, 1'b0, 8'h00},
    '{WR, 16'h0400, 8'h5A, 1'b1, 8'h00}, '{RD, 16'h0400, 8'h00, 1'b0, 8'h5A},
    '{eeprom_host_pkg::CMD_UNPROT, 16'h0000, 8'h00, 1'b0, 8'h00},
    '{WR, 16'h0400, 8'h66, 1'b1, 8'h00}, '{RD, 16'h0400, 8'h00, 1'b0, 8'h66}};
  logic        clk_sys = 1'b0, rst = 1'b1, cmd_last = 1'b0, cmd_valid = 1'b0, refused;
  logic [1:0]  cmd = 2'h0;
  logic [15:0] cmd_addr = 16'h0000, byte_address;
  logic [7:0]  cmd_data = 8'h00, rd_data, data_lines_out, dq, data_lines_in;
  logic        cmd_ready, rd_valid, busy, chip_sel_n, out_en_n, wr_en_n, data_lines_oe_n;
  row_t        r;
  int          num_errors = 0, cmp_count = 0;
  always #2.5 clk_sys = ~clk_sys;
  // The shared wire carries the host's byte only while its drivers are on.
  assign data_lines_in = data_lines_oe_n ? dq : data_lines_out;
  // The poll limit lies well above the model's programming time, so status ends a poll.
  eeprom_host #(.BYTE_LOAD_CYC(40), .WRITE_CYCLE_CYC(256), .PAGE_GAP_CYC(8)) dut (
    .clk_sys(clk_sys), .rst(rst), .cmd(cmd), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_last(cmd_last), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rd_data(rd_data),
    .rd_valid(rd_valid), .busy(busy), .byte_address(byte_address), .chip_sel_n(chip_sel_n),
    .out_en_n(out_en_n), .wr_en_n(wr_en_n), .data_lines_in(data_lines_in),
    .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n));
  eeprom_model #(.BL(40), .WC(64)) dev (.clk_sys(clk_sys), .byte_address(byte_address),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n), .bus(data_lines_in), .dq(dq));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task finish_test;
    $display("mismatches %0d, compares %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // Pushes one entry and holds it until the FIFO takes it; a long refusal ends the run.
  task push(input row_t p);
    int i;
    {cmd, cmd_addr, cmd_data, cmd_last, cmd_valid} = {p.c, p.a, p.d, p.l, 1'b1};
    for (i = 0; i < 4000 && cmd_ready !== 1'b1; i++) begin
      refused = 1'b1;
      @(negedge clk_sys);
    end
    if (i == 4000) begin
      check(16'h0000, 16'h0001);
      finish_test();
    end
    @(negedge clk_sys);
    cmd_valid = 1'b0;
    @(negedge clk_sys);
  endtask : push
  task read_chk(input logic [15:0] a, input logic [7:0] e);
    int i;
    push('{RD, a, 8'h00, 1'b0, 8'h00});
    for (i = 0; i < 4000 && rd_valid !== 1'b1; i++) @(negedge clk_sys);
    if (i == 4000) begin
      check(16'h0000, 16'h0001);
      finish_test();
    end
    check(rd_data, e);
  endtask : read_chk
  // Main sequence: rows first, then the FIFO overflow page and a mid-run reset.
  initial begin
    repeat (4) @(negedge clk_sys);
    rst = 1'b0;
    foreach (ROWS[k]) begin
      if (ROWS[k].c == RD) read_chk(ROWS[k].a, ROWS[k].e);
      else push(ROWS[k]);
    end
    refused = 1'b0;
    r = ROWS[0];
    for (int k = 0; k < 12; k++) begin
      r.a = 16'h0500 + 16'(k);
      r.d = 8'hC0 + 8'(k);
      r.l = (k == 11);
      push(r);
    end
    check(16'(refused), 16'h0001);
    read_chk(16'h0500, 8'hC0);
    read_chk(16'h050B, 8'hCB);
    rst = 1'b1;
    repeat (2) @(negedge clk_sys);
    check({chip_sel_n, out_en_n, wr_en_n, data_lines_oe_n, busy, rd_valid}, 16'h003C);
    rst = 1'b0;
    read_chk(16'h0081, 8'h3C);
    finish_test();
  end
endmodule : tb_eeprom_host
